/* lfc_byte_fifo.sv */
`timescale 1ns/10ps
module lfc_byte_fifo (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in
);
  typedef struct packed {
    logic [lfc_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic wptr;
    logic rptr;
    logic [1:0] count;
  } lfc_fifo_t;

  lfc_fifo_t st_reg;
  lfc_fifo_t st_next;
  logic push;
  logic pop;

  assign in_ready_out = (st_reg.count != 2'(lfc_pkg::FIFO_DEPTH));
  assign out_valid_out = (st_reg.count != 2'd0);
  assign out_data_out = st_reg.mem[st_reg.rptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data_in;
      st_next.wptr = ~st_reg.wptr;
    end
    if (pop) begin
      st_next.rptr = ~st_reg.rptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'd1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'd1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : lfc_byte_fifo

/* lfc_engine_model.sv */
`timescale 1ns/10ps
module lfc_engine_model #(
  parameter int DONE_DELAY = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // From the controller
  input wire logic start_frame_in,
  input wire logic rx_ready_in,
  // Events injected by the bench
  input wire lfc_pkg::lfc_event_t pulse_in,
  // To the controller
  output lfc_pkg::lfc_event_t event_out,
  output lfc_pkg::lfc_byte_t rx_byte_out
);
  logic [7:0] queue_q[$];
  logic [7:0] last_reg;
  int count_reg;
  logic done_reg;

  task automatic offer(input logic [7:0] b);
    queue_q.push_back(b);
  endtask : offer

  always_comb begin
    event_out = pulse_in;
    event_out.frame_done = pulse_in.frame_done | done_reg;
  end

  // Frame completes a fixed time after each start
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= 0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (count_reg == 1);
      if (start_frame_in === 1'b1) begin
        count_reg <= DONE_DELAY;
      end else if (count_reg > 0) begin
        count_reg <= count_reg - 1;
      end
    end
  end

  // Byte held until taken; idle data is the inverse of the last byte
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_reg = 8'h00;
      rx_byte_out <= {1'b0, 8'hff};
    end else begin
      if (rx_byte_out.valid && rx_ready_in === 1'b1) begin
        last_reg = queue_q.pop_front();
      end
      rx_byte_out <= (queue_q.size() != 0) ? {1'b1, queue_q[0]} : {1'b0, ~last_reg};
    end
  end
endmodule : lfc_engine_model

/* lfc_frame_control.sv */
`timescale 1ns/10ps
//Contract
// - Slave stop bit ignores traffic until break
// - Stop and clear bits: write-one only, read zero
// - Slave sleep set: sleep on frame or timeout
// - Slave sleep clear: resume on wakeup event
// - Direction bit: zero receive, one transmit
// - Data acknowledge bit clears itself
// - Clear-interrupt bit clears bus interrupt flag
// - Clear-error bit clears all error indications
// - Wakeup request drives wakeup, then self-clears
// - Master start bit begins frame transmission
// - Start bit clears on completion or error
module lfc_frame_control #(
  parameter int unsigned WAKE_CYCLES = lfc_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Frame engine events and received bytes
  input wire lfc_pkg::lfc_event_t event_in,
  input wire lfc_pkg::lfc_byte_t rx_byte_in,
  output logic rx_ready_out,
  // Frame engine control
  output logic start_frame_out,
  output logic frame_direction_select_out,
  output logic data_request_acknowledge_out,
  output logic wakeup_drive_out,
  output logic sleeping_out,
  output logic ignoring_out
);
  typedef struct packed {
    logic master_mode;
    logic sleep;
    logic dir;
    logic data_request_acknowledge;
    logic wakeup_request;
    logic start_request;
    logic sleeping;
    logic ignoring;
    logic int_flag;
    logic err_flag;
    logic [lfc_pkg::ERR_W-1:0] err_bits;
    logic start_pulse;
    logic [31:0] prdata;
    logic pslverr;
  } lfc_ctl_t;

  lfc_ctl_t st_reg;
  lfc_ctl_t st_next;

  logic setup;
  logic wr;
  logic rd;
  logic [7:0] wb;
  logic ctl_wr;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic fifo_in_valid;
  logic wake_busy;
  logic wake_done;
  logic wake_start;
  logic ev_done;
  logic ev_req;
  logic ev_sleep;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, lfc_pkg::ADDR_CONFIG) || hit(a, lfc_pkg::ADDR_STATUS) ||
             hit(a, lfc_pkg::ADDR_CONTROL) || hit(a, lfc_pkg::ADDR_ERROR) ||
             hit(a, lfc_pkg::ADDR_RXDATA);
  endfunction : mapped

  // Zero wait state: read data is captured in the setup cycle
  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pwrite_in;
  assign rd = psel_in && penable_in && !pwrite_in;
  assign wb = pwdata_in[7:0];
  assign ctl_wr = wr && hit(paddr_in, lfc_pkg::ADDR_CONTROL);
  assign pready_out = 1'b1;
  assign prdata_out = st_reg.prdata;
  assign pslverr_out = st_reg.pslverr && psel_in && penable_in;

  // Bytes and done, request and sleep-frame events are dropped while ignoring; error, wakeup and timeout events still pass
  assign ev_done = event_in.frame_done && !st_reg.ignoring;
  assign ev_req = event_in.data_request && !st_reg.ignoring;
  assign ev_sleep = (event_in.sleep_frame && !st_reg.ignoring) || event_in.idle_timeout;
  assign fifo_in_valid = rx_byte_in.valid && !st_reg.ignoring;
  assign fifo_pop = rd && hit(paddr_in, lfc_pkg::ADDR_RXDATA) && fifo_valid;

  lfc_byte_fifo u_rx_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(fifo_in_valid),
    .in_data_in(rx_byte_in.data),
    .in_ready_out(rx_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  assign wake_start = st_reg.wakeup_request && !wake_busy && !wake_done;

  lfc_pulse_timer #(
    .CYCLES(WAKE_CYCLES)
  ) u_wake_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(wake_start),
    .busy_out(wake_busy),
    .done_out(wake_done)
  );

  always_comb begin
    st_next = st_reg;
    st_next.start_pulse = 1'b0;
    // Hardware clear first, so a software set in the same cycle wins, except a start write while start_request is still set
    st_next.data_request_acknowledge = 1'b0;
    if (wake_done) begin
      st_next.wakeup_request = 1'b0;
    end
    if (event_in.frame_done || event_in.frame_error) begin
      st_next.start_request = 1'b0;
    end
    if (event_in.sync_break) begin
      st_next.ignoring = 1'b0;
    end
    if (!st_reg.master_mode && st_reg.sleep && ev_sleep) begin
      st_next.sleeping = 1'b1;
    end
    if (!st_reg.master_mode && !st_reg.sleep && event_in.wakeup) begin
      st_next.sleeping = 1'b0;
    end
    if (ctl_wr && wb[lfc_pkg::CTL_CLR_INT]) begin
      st_next.int_flag = 1'b0;
    end
    if (ctl_wr && wb[lfc_pkg::CTL_CLR_ERR]) begin
      st_next.err_flag = 1'b0;
      st_next.err_bits = '0;
    end
    if (ev_done || event_in.frame_error || ev_req || event_in.wakeup) begin
      st_next.int_flag = 1'b1;
    end
    if (event_in.frame_error) begin
      st_next.err_flag = 1'b1;
      st_next.err_bits = st_next.err_bits | event_in.error_code;
    end
    if (wr && hit(paddr_in, lfc_pkg::ADDR_CONFIG)) begin
      st_next.master_mode = pwdata_in[lfc_pkg::CFG_MASTER];
    end
    if (ctl_wr) begin
      st_next.sleep = wb[lfc_pkg::CTL_SLEEP];
      st_next.dir = wb[lfc_pkg::CTL_DIR];
      if (wb[lfc_pkg::CTL_STOP] && !st_reg.master_mode) begin
        st_next.ignoring = 1'b1;
      end
      if (wb[lfc_pkg::CTL_DATA_REQUEST_ACKNOWLEDGE] && !st_reg.master_mode) begin
        st_next.data_request_acknowledge = 1'b1;
      end
      if (wb[lfc_pkg::CTL_WUP]) begin
        st_next.wakeup_request = 1'b1;
        st_next.sleeping = 1'b0;
      end
      if (wb[lfc_pkg::CTL_START] && st_reg.master_mode && !st_reg.start_request) begin
        st_next.start_request = 1'b1;
        st_next.start_pulse = 1'b1;
      end
    end
    if (setup) begin
      st_next.pslverr = !mapped(paddr_in);
      st_next.prdata = 32'h0000_0000;
      case (paddr_in)
        lfc_pkg::ADDR_CONFIG: st_next.prdata[lfc_pkg::CFG_MASTER] = st_reg.master_mode;
        lfc_pkg::ADDR_STATUS: begin
          st_next.prdata[lfc_pkg::STS_SLEEPING] = st_reg.sleeping;
          st_next.prdata[lfc_pkg::STS_IGNORING] = st_reg.ignoring;
          st_next.prdata[lfc_pkg::STS_ERROR] = st_reg.err_flag;
          st_next.prdata[lfc_pkg::STS_INT] = st_reg.int_flag;
          st_next.prdata[lfc_pkg::STS_BUSY] = st_reg.start_request;
          st_next.prdata[lfc_pkg::STS_RXAVAIL] = fifo_valid;
        end
        lfc_pkg::ADDR_CONTROL: begin
          // Stop and both clear bits always read back as zero
          st_next.prdata[lfc_pkg::CTL_SLEEP] = st_reg.sleep;
          st_next.prdata[lfc_pkg::CTL_DIR] = st_reg.dir;
          st_next.prdata[lfc_pkg::CTL_DATA_REQUEST_ACKNOWLEDGE] = st_reg.data_request_acknowledge;
          st_next.prdata[lfc_pkg::CTL_WUP] = st_reg.wakeup_request;
          st_next.prdata[lfc_pkg::CTL_START] = st_reg.start_request;
        end
        lfc_pkg::ADDR_ERROR: st_next.prdata[lfc_pkg::ERR_W-1:0] = st_reg.err_bits;
        lfc_pkg::ADDR_RXDATA: begin
          // Empty buffer reads as zero, not as a stale byte
          st_next.prdata[7:0] = fifo_valid ? fifo_data : 8'h00;
          st_next.prdata[lfc_pkg::RXD_VALID] = fifo_valid;
        end
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign start_frame_out = st_reg.start_pulse;
  assign frame_direction_select_out = st_reg.dir;
  assign data_request_acknowledge_out = st_reg.data_request_acknowledge;
  assign wakeup_drive_out = wake_busy;
  assign sleeping_out = st_reg.sleeping;
  assign ignoring_out = st_reg.ignoring;

  a_ctl_reads_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (setup && hit(paddr_in, lfc_pkg::ADDR_CONTROL)) |=>
      (prdata_out[lfc_pkg::CTL_STOP] == 1'b0 && prdata_out[lfc_pkg::CTL_CLR_INT] == 1'b0 &&
       prdata_out[lfc_pkg::CTL_CLR_ERR] == 1'b0))
    else $error("write-only control bits read as one");

  a_ignore_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ignoring_out && !event_in.sync_break) |=> ignoring_out)
    else $error("traffic resumed before a break");

  a_stop_sets: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_STOP] && !st_reg.master_mode) |=> ignoring_out)
    else $error("stop write did not block traffic");

  a_ignore_drops: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ignoring_out && rx_byte_in.valid) |-> !fifo_in_valid)
    else $error("byte accepted while ignoring traffic");

  a_sleep_entry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!st_reg.master_mode && st_reg.sleep && event_in.idle_timeout && !ctl_wr) |=> sleeping_out)
    else $error("no sleep after idle timeout");

  a_wake_resume: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!st_reg.master_mode && !st_reg.sleep && event_in.wakeup) |=> !sleeping_out)
    else $error("still asleep after wakeup");

  a_dir_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ctl_wr |=> (frame_direction_select_out == $past(wb[lfc_pkg::CTL_DIR])))
    else $error("direction does not follow write");

  a_data_request_acknowledge_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (data_request_acknowledge_out && !ctl_wr) |=> !data_request_acknowledge_out)
    else $error("acknowledge bit did not clear");

  a_int_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_CLR_INT] && !event_in.frame_error && !ev_done &&
     !ev_req && !event_in.wakeup) |=> !st_reg.int_flag)
    else $error("interrupt flag not cleared");

  a_err_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_CLR_ERR] && !event_in.frame_error) |=>
      (!st_reg.err_flag && st_reg.err_bits == '0))
    else $error("error indications not cleared");

  a_wake_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_WUP] && !st_reg.wakeup_request && !wake_busy) |=>
      (!sleeping_out ##1 wakeup_drive_out))
    else $error("wakeup not driven after request");

  a_start_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_START] && st_reg.master_mode && !st_reg.start_request) |=>
      (start_frame_out && st_reg.start_request) ##1 !start_frame_out)
    else $error("start request did not launch a frame");

  a_start_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ((event_in.frame_done || event_in.frame_error) && !ctl_wr) |=> !st_reg.start_request)
    else $error("start bit kept after frame end");

  a_start_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_START] && (!st_reg.master_mode || st_reg.start_request)) |=> !start_frame_out)
    else $error("refused start request launched a frame");

  a_wake_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wake_done && !(ctl_wr && wb[lfc_pkg::CTL_WUP])) |=> !st_reg.wakeup_request)
    else $error("wakeup request kept after drive ended");

  a_data_request_acknowledge_slave: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && wb[lfc_pkg::CTL_DATA_REQUEST_ACKNOWLEDGE] && !st_reg.master_mode) |=> data_request_acknowledge_out)
    else $error("acknowledge write not passed on");

  a_clear_zero_noop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ctl_wr && !wb[lfc_pkg::CTL_CLR_INT] && st_reg.int_flag) |=> st_reg.int_flag)
    else $error("zero write cleared interrupt flag");

  a_sleep_frame: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!st_reg.master_mode && st_reg.sleep && event_in.sleep_frame && !ignoring_out &&
     !ctl_wr) |=> sleeping_out)
    else $error("no sleep after sleep frame");
endmodule : lfc_frame_control

/* lfc_frame_control_tb.sv */
`timescale 1ns/10ps
module lfc_frame_control_tb;
  localparam int WAKE = 8;
  localparam logic [10:0] E_ERR5 = 11'h205;
  localparam logic [10:0] E_BREAK = 11'h100;
  localparam logic [10:0] E_SLEEP = 11'h080;
  localparam logic [10:0] E_IDLE = 11'h040;
  localparam logic [10:0] E_WAKE = 11'h020;
  localparam logic [10:0] E_DREQ = 11'h010;
  logic clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, err, rx_ready;
  logic start_frame, dir, data_request_acknowledge, wdrive, sleeping, ignoring;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  lfc_pkg::lfc_event_t evt, pulse;
  lfc_pkg::lfc_byte_t rx_byte;
  int mismatches, checked, starts, dtacks, drives;

  lfc_frame_control #(.WAKE_CYCLES(WAKE)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .event_in(evt), .rx_byte_in(rx_byte),
    .rx_ready_out(rx_ready), .start_frame_out(start_frame),
    .frame_direction_select_out(dir), .data_request_acknowledge_out(data_request_acknowledge),
    .wakeup_drive_out(wdrive), .sleeping_out(sleeping), .ignoring_out(ignoring)
  );

  lfc_engine_model u_eng (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .start_frame_in(start_frame),
    .rx_ready_in(rx_ready), .pulse_in(pulse), .event_out(evt), .rx_byte_out(rx_byte)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (start_frame === 1'b1) starts++;
    if (data_request_acknowledge === 1'b1) dtacks++;
    if (wdrive === 1'b1) drives++;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk

  // Pulse lasts exactly one sampled cycle
  task automatic ev(input logic [10:0] e);
    @(posedge clk_in);
    pulse <= e;
    @(posedge clk_in);
    pulse <= '0;
    #1;
  endtask : ev

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    end_of_test;
  end

  initial begin
    {mismatches, checked, starts, dtacks, drives} = '0;
    {psel, penable, pwrite, paddr, pwdata, pulse} = '0;
    reset_n_in = 1'b0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rdchk("control reset", 8'h08, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    chk("ready", 32'h1, {31'h0, pready});
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h21);
    chk("direction", 32'h1, {31'h0, dir});
    rdchk("start pending", 8'h08, 32'h21);
    chk("start pulse", 32'h1, starts);
    repeat (30) @(posedge clk_in);
    rdchk("start done", 8'h08, 32'h20);
    rdchk("interrupt set", 8'h04, 32'h08);
    wr(8'h08, 32'h08);
    chk("direction", 32'h0, {31'h0, dir});
    rdchk("interrupt cleared", 8'h04, 32'h0);
    rdchk("clear reads zero", 8'h08, 32'h0);
    wr(8'h08, 32'h01);
    ev(E_ERR5);
    rdchk("start on error", 8'h08, 32'h0);
    repeat (30) @(posedge clk_in);
    rdchk("error code", 8'h0c, 32'h5);
    rdchk("error status", 8'h04, 32'h0c);
    wr(8'h08, 32'h04);
    rdchk("error cleared", 8'h0c, 32'h0);
    rdchk("status error", 8'h04, 32'h08);
    wr(8'h08, 32'h08);
    // Slave mode from here on
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h01);
    rdchk("slave start refused", 8'h08, 32'h0);
    chk("no slave start", 32'h2, starts);
    ev(E_DREQ);
    wr(8'h08, 32'h10);
    rdchk("ack self clear", 8'h08, 32'h0);
    chk("ack pulse", 32'h1, dtacks);
    wr(8'h08, 32'h08);
    wr(8'h08, 32'h80);
    chk("ignoring", 32'h1, {31'h0, ignoring});
    rdchk("stop reads zero", 8'h08, 32'h0);
    ev(E_DREQ);
    rdchk("request dropped", 8'h04, 32'h02);
    ev(E_BREAK);
    chk("break resumes", 32'h0, {31'h0, ignoring});
    wr(8'h08, 32'h40);
    ev(E_SLEEP);
    chk("sleep on frame", 32'h1, {31'h0, sleeping});
    wr(8'h08, 32'h0);
    ev(E_WAKE);
    chk("wake resumes", 32'h0, {31'h0, sleeping});
    wr(8'h08, 32'h40);
    ev(E_IDLE);
    chk("sleep on idle", 32'h1, {31'h0, sleeping});
    wr(8'h08, 32'h42);
    chk("wake request", 32'h0, {31'h0, sleeping});
    repeat (WAKE + 6) @(posedge clk_in);
    chk("wake drive cycles", WAKE, drives);
    rdchk("wake request clears", 8'h08, 32'h40);
    // Third byte stalls until the first read frees a buffer entry
    wr(8'h08, 32'h0);
    u_eng.offer(8'ha5);
    u_eng.offer(8'h5a);
    u_eng.offer(8'h3c);
    repeat (8) @(posedge clk_in);
    #1;
    chk("buffer full", 32'h0, {31'h0, rx_ready});
    rdchk("byte one", 8'h10, 32'h1a5);
    rdchk("byte two", 8'h10, 32'h15a);
    rdchk("byte three", 8'h10, 32'h13c);
    rdchk("buffer empty", 8'h10, 32'h0);
    end_of_test;
  end
endmodule : lfc_frame_control_tb

/* lfc_pkg.sv */
package lfc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_ERROR = 8'h0c;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;

  // Control register field positions
  localparam int unsigned CTL_STOP = 7;
  localparam int unsigned CTL_SLEEP = 6;
  localparam int unsigned CTL_DIR = 5;
  localparam int unsigned CTL_DATA_REQUEST_ACKNOWLEDGE = 4;
  localparam int unsigned CTL_CLR_INT = 3;
  localparam int unsigned CTL_CLR_ERR = 2;
  localparam int unsigned CTL_WUP = 1;
  localparam int unsigned CTL_START = 0;

  // Status register field positions
  localparam int unsigned STS_SLEEPING = 0;
  localparam int unsigned STS_IGNORING = 1;
  localparam int unsigned STS_ERROR = 2;
  localparam int unsigned STS_INT = 3;
  localparam int unsigned STS_BUSY = 4;
  localparam int unsigned STS_RXAVAIL = 5;

  localparam int unsigned CFG_MASTER = 0;
  localparam int unsigned RXD_VALID = 8;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int unsigned ERR_W = 4;
  localparam int unsigned FIFO_DEPTH = 2;

  // Wakeup drive time on the bus
  localparam int unsigned WAKE_TIME_US = 250;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;

  // Events from the frame engine, same clock
  typedef struct packed {
    logic frame_done;
    logic frame_error;
    logic sync_break;
    logic sleep_frame;
    logic idle_timeout;
    logic wakeup;
    logic data_request;
    logic [ERR_W-1:0] error_code;
  } lfc_event_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lfc_byte_t;
endpackage : lfc_pkg

/* lfc_pulse_timer.sv */
`timescale 1ns/10ps
module lfc_pulse_timer #(
  parameter int unsigned CYCLES = lfc_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] cnt;
  } lfc_timer_t;

  lfc_timer_t st_reg;
  lfc_timer_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      if (start_in) begin
        st_next.busy = 1'b1;
        st_next.cnt = 16'(CYCLES - 1);
      end
    end else if (st_reg.cnt == 16'h0000) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_out = st_reg.busy;
  assign done_out = st_reg.done;
endmodule : lfc_pulse_timer
